// File: hw/osrv_channel.sv
// osrv_channel: integrator and applied correction of one output servo
// assumes offset_high is a settled comparator level, synchronous to core_clk
`timescale 1ns/1ps
module osrv_channel
(
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  input  wire logic                   master_run,
  input  wire logic                   channel_en,
  input  wire osrv_pkg::osrv_mode_type mode,
  input  wire logic                   step_en,
  input  wire logic [7:0]             preset,
  input  wire logic                   offset_high,
  output logic [7:0]                  integrator,
  output logic [7:0]                  correction
);
  import osrv_pkg::*;

  logic signed [7:0] integ_reg;
  logic signed [7:0] integ_next;
  logic [7:0]        corr_reg;
  logic [7:0]        corr_next;
  logic              measuring;
  logic              applying;

  assign measuring = mode[1];
  assign applying  = mode[0];

  always_comb
  begin
    integ_next = integ_reg;
    corr_next  = corr_reg;
    if (!master_run)
    begin
      // servo held in reset, channel enables ignored
      integ_next = RST_INTEG;
      corr_next  = RST_INTEG;
    end
    else if (channel_en)
    begin
      if (!measuring)
      begin
        integ_next = preset;
      end
      else if (step_en)
      begin
        // step against the sensed offset, saturating
        if (offset_high && integ_reg != INTEG_MIN)
        begin
          integ_next = integ_reg - 8'sh01;
        end
        else if (!offset_high && integ_reg != INTEG_MAX)
        begin
          integ_next = integ_reg + 8'sh01;
        end
      end
      if (applying)
      begin
        corr_next = integ_next;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      integ_reg <= RST_INTEG;
      corr_reg  <= RST_INTEG;
    end
    else
    begin
      integ_reg <= integ_next;
      corr_reg  <= corr_next;
    end
  end

  assign integrator = integ_reg;
  assign correction = corr_reg;

endmodule : osrv_channel

// File: hw/osrv_pkg.sv
// osrv_pkg: shared constants and types of the output dc offset servo register bank
// assumes a 200 MHz core clock and a 32-bit ahb-lite register bus
package osrv_pkg;

  // clock and servo step timing
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int SERVO_STEP_NS   = 1000;
  localparam int SERVO_STEP_CYC  = (SERVO_STEP_NS * 1000) / CLK_PERIOD_PS;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_SERVO_CONTROL    = 8'h43;
  localparam logic [7:0] IDX_SERVO_MODE       = 8'h45;
  localparam logic [7:0] IDX_HP_LEFT_PRESET   = 8'h47;
  localparam logic [7:0] IDX_HP_RIGHT_PRESET  = 8'h48;
  localparam logic [7:0] IDX_LINE_LEFT_PRESET = 8'h49;
  localparam logic [7:0] IDX_LINE_RIGHT_PRESET = 8'h4a;
  localparam logic [7:0] IDX_HP_LEFT_INTEG    = 8'h51;
  localparam logic [7:0] IDX_HP_RIGHT_INTEG   = 8'h52;
  localparam logic [7:0] IDX_LINE_LEFT_INTEG  = 8'h53;
  localparam logic [7:0] IDX_LINE_RIGHT_INTEG = 8'h54;

  // control field positions
  localparam int MASTER_RUN_BIT  = 4;
  localparam int ENABLES_LSB     = 0;
  localparam int ENABLES_W       = 4;
  localparam int MODE_LSB        = 0;
  localparam int MODE_W          = 2;

  // channel numbering inside the enable field
  localparam int CH_LINE_RIGHT   = 0;
  localparam int CH_LINE_LEFT    = 1;
  localparam int CH_HP_RIGHT     = 2;
  localparam int CH_HP_LEFT      = 3;
  localparam int NUM_CHANNELS    = 4;

  // reset values
  localparam logic       RST_MASTER_RUN = 1'b1;
  localparam logic [3:0] RST_ENABLES    = 4'h0;
  localparam logic [7:0] RST_PRESET     = 8'h00;
  localparam logic [7:0] RST_INTEG      = 8'h00;

  // integrator limits, two's complement
  localparam logic signed [7:0] INTEG_MAX = 8'sh7f;
  localparam logic signed [7:0] INTEG_MIN = -8'sh80;

  // ahb-lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic       HRESP_OKAY    = 1'b0;

  typedef enum logic [1:0] {
    MODE_WRITE_HOLD     = 2'b00,
    MODE_WRITE_APPLY    = 2'b01,
    MODE_MEASURE_HOLD   = 2'b10,
    MODE_MEASURE_APPLY  = 2'b11
  } osrv_mode_type;

  localparam osrv_mode_type RST_MODE = MODE_WRITE_HOLD;

  typedef struct packed {
    logic          servo_master_run;
    logic [3:0]    servo_channel_enables;
    osrv_mode_type servo_operating_mode;
  } osrv_ctrl_type;

endpackage : osrv_pkg

// File: hw/osrv_regs.sv
// osrv_regs: ahb-lite register bank of the four-output dc offset servo
// assumes a single ahb-lite master; hready is this slave's hreadyout
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module osrv_regs
#(
  parameter int STEP_CYCLES = osrv_pkg::SERVO_STEP_CYC,
  parameter int ADDR_W      = 12
)
(
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic [3:0]        offset_high,
  output logic [7:0]             headphone_left_out,
  output logic [7:0]             headphone_right_out,
  output logic [7:0]             line_left_out,
  output logic [7:0]             line_right_out,
  output logic                   servo_active
);
  import osrv_pkg::*;

  function automatic logic hits(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    hits = (a == ADDR_W'({idx, 2'b00}));
  endfunction : hits

  // address phase capture
  logic              accept;
  logic              wr_pend_reg;
  logic              wr_pend_next;
  logic [ADDR_W-1:0] wr_addr_reg;
  logic [ADDR_W-1:0] wr_addr_next;
  logic [31:0]       rdata_reg;
  logic [31:0]       rdata_next;

  // software-visible state
  osrv_ctrl_type     ctrl_reg;
  osrv_ctrl_type     ctrl_next;
  logic [7:0]        preset_reg [NUM_CHANNELS];
  logic [7:0]        preset_next [NUM_CHANNELS];
  logic [7:0]        integ [NUM_CHANNELS];
  logic [7:0]        corr [NUM_CHANNELS];
  logic              step_en;

  assign accept = hsel && htrans[1] && hready;

  // register writes land in the data phase
  always_comb
  begin
    wr_pend_next = accept && hwrite;
    wr_addr_next = accept ? haddr : wr_addr_reg;
    ctrl_next    = ctrl_reg;
    for (int i = 0; i < NUM_CHANNELS; i++)
    begin
      preset_next[i] = preset_reg[i];
    end
    if (wr_pend_reg)
    begin
      if (hits(wr_addr_reg, IDX_SERVO_CONTROL))
      begin
        ctrl_next.servo_master_run      = hwdata[MASTER_RUN_BIT];
        ctrl_next.servo_channel_enables = hwdata[ENABLES_LSB +: ENABLES_W];
      end
      else if (hits(wr_addr_reg, IDX_SERVO_MODE))
      begin
        ctrl_next.servo_operating_mode = osrv_mode_type'(hwdata[MODE_LSB +: MODE_W]);
      end
      else if (hits(wr_addr_reg, IDX_HP_LEFT_PRESET))
      begin
        preset_next[CH_HP_LEFT] = hwdata[7:0];
      end
      else if (hits(wr_addr_reg, IDX_HP_RIGHT_PRESET))
      begin
        preset_next[CH_HP_RIGHT] = hwdata[7:0];
      end
      else if (hits(wr_addr_reg, IDX_LINE_LEFT_PRESET))
      begin
        preset_next[CH_LINE_LEFT] = hwdata[7:0];
      end
      else if (hits(wr_addr_reg, IDX_LINE_RIGHT_PRESET))
      begin
        preset_next[CH_LINE_RIGHT] = hwdata[7:0];
      end
      // readback and unmapped addresses ignore writes
    end
  end

  // read data sampled at the address phase, writable registers from next values (integrators from their registers) so that
  // a write in its data phase is seen by a read right behind it
  always_comb
  begin
    rdata_next = rdata_reg;
    if (accept && !hwrite)
    begin
      rdata_next = 32'h0000_0000;
      if (hits(haddr, IDX_SERVO_CONTROL))
      begin
        rdata_next[MASTER_RUN_BIT] = ctrl_next.servo_master_run;
        rdata_next[ENABLES_LSB +: ENABLES_W] = ctrl_next.servo_channel_enables;
      end
      else if (hits(haddr, IDX_SERVO_MODE))
      begin
        rdata_next[MODE_LSB +: MODE_W] = ctrl_next.servo_operating_mode;
      end
      else if (hits(haddr, IDX_HP_LEFT_PRESET))
      begin
        rdata_next[7:0] = preset_next[CH_HP_LEFT];
      end
      else if (hits(haddr, IDX_HP_RIGHT_PRESET))
      begin
        rdata_next[7:0] = preset_next[CH_HP_RIGHT];
      end
      else if (hits(haddr, IDX_LINE_LEFT_PRESET))
      begin
        rdata_next[7:0] = preset_next[CH_LINE_LEFT];
      end
      else if (hits(haddr, IDX_LINE_RIGHT_PRESET))
      begin
        rdata_next[7:0] = preset_next[CH_LINE_RIGHT];
      end
      else if (hits(haddr, IDX_HP_LEFT_INTEG))
      begin
        rdata_next[7:0] = integ[CH_HP_LEFT];
      end
      else if (hits(haddr, IDX_HP_RIGHT_INTEG))
      begin
        rdata_next[7:0] = integ[CH_HP_RIGHT];
      end
      else if (hits(haddr, IDX_LINE_LEFT_INTEG))
      begin
        rdata_next[7:0] = integ[CH_LINE_LEFT];
      end
      else if (hits(haddr, IDX_LINE_RIGHT_INTEG))
      begin
        rdata_next[7:0] = integ[CH_LINE_RIGHT];
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      rdata_reg   <= 32'h0000_0000;
      ctrl_reg.servo_master_run      <= RST_MASTER_RUN;
      ctrl_reg.servo_channel_enables <= RST_ENABLES;
      ctrl_reg.servo_operating_mode  <= RST_MODE;
      for (int i = 0; i < NUM_CHANNELS; i++)
      begin
        preset_reg[i] <= RST_PRESET;
      end
    end
    else
    begin
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      rdata_reg   <= rdata_next;
      ctrl_reg    <= ctrl_next;
      for (int i = 0; i < NUM_CHANNELS; i++)
      begin
        preset_reg[i] <= preset_next[i];
      end
    end
  end

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;
  assign hrdata    = rdata_reg;

  osrv_step_divider #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_step (
    .core_clk (core_clk),
    .reset    (reset),
    .run      (ctrl_reg.servo_master_run),
    .step_en  (step_en)
  );

  generate
    for (genvar ch = 0; ch < NUM_CHANNELS; ch++)
    begin : g_chan
      osrv_channel u_chan (
        .core_clk    (core_clk),
        .reset       (reset),
        .master_run  (ctrl_reg.servo_master_run),
        .channel_en  (ctrl_reg.servo_channel_enables[ch]),
        .mode        (ctrl_reg.servo_operating_mode),
        .step_en     (step_en),
        .preset      (preset_reg[ch]),
        .offset_high (offset_high[ch]),
        .integrator  (integ[ch]),
        .correction  (corr[ch])
      );
    end
  endgenerate

  assign headphone_left_out  = corr[CH_HP_LEFT];
  assign headphone_right_out = corr[CH_HP_RIGHT];
  assign line_left_out       = corr[CH_LINE_LEFT];
  assign line_right_out      = corr[CH_LINE_RIGHT];
  assign servo_active        = ctrl_reg.servo_master_run && (|ctrl_reg.servo_channel_enables);

endmodule : osrv_regs

// File: hw/osrv_step_divider.sv
// osrv_step_divider: one-cycle step enable for the servo integrators
// assumes core_clk at the rate the step count was derived for
`timescale 1ns/1ps
module osrv_step_divider
#(
  parameter int STEP_CYCLES = osrv_pkg::SERVO_STEP_CYC
)
(
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic run,
  output logic      step_en
);
  import osrv_pkg::*;

  localparam int CW = $clog2(STEP_CYCLES + 1);

  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic          step_reg;
  logic          step_next;

  always_comb
  begin
    count_next = count_reg;
    step_next  = 1'b0;
    if (!run)
    begin
      count_next = '0;
    end
    else if (count_reg == CW'(STEP_CYCLES - 1))
    begin
      count_next = '0;
      step_next  = 1'b1;
    end
    else
    begin
      count_next = count_reg + CW'(1);
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      count_reg <= '0;
      step_reg  <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      step_reg  <= step_next;
    end
  end

  assign step_en = step_reg;

endmodule : osrv_step_divider

// File: sim/osrv_regs_chk.sv
// osrv_regs_chk: port-level assertions for osrv_regs
// assumes hready fed back from hreadyout, single word transfers
`timescale 1ns/1ps
module osrv_regs_chk
#(
  parameter int STEP_CYCLES = 200,
  parameter int ADDR_W      = 12
)
(
  input wire logic              core_clk,
  input wire logic              reset,
  input wire logic              hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [2:0]        hsize,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire logic [31:0]       hrdata,
  input wire logic [3:0]        offset_high,
  input wire logic [7:0]        headphone_left_out,
  input wire logic [7:0]        headphone_right_out,
  input wire logic [7:0]        line_left_out,
  input wire logic [7:0]        line_right_out,
  input wire logic              servo_active
);
  import osrv_pkg::*;
  localparam logic [ADDR_W-1:0] A_CTRL = ADDR_W'({IDX_SERVO_CONTROL, 2'b00});
  localparam logic [ADDR_W-1:0] A_MODE = ADDR_W'({IDX_SERVO_MODE, 2'b00});
  logic              wr_dp;
  logic              rd_dp;
  logic [ADDR_W-1:0] dp_addr;
  logic [4:0]        sh_ctrl;
  logic [1:0]        sh_mode;
  wire               take = hsel && htrans[1] && hready;
  wire  [31:0]       outs = {headphone_left_out, headphone_right_out, line_left_out,
                             line_right_out};
  // shadow of control and mode, updated at the end of each write data phase
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      wr_dp   <= 1'b0;
      rd_dp   <= 1'b0;
      dp_addr <= '0;
      sh_ctrl <= 5'h10;
      sh_mode <= 2'h0;
    end
    else
    begin
      wr_dp <= take && hwrite;
      rd_dp <= take && !hwrite;
      if (take)
        dp_addr <= haddr;
      if (wr_dp && dp_addr == A_CTRL)
        sh_ctrl <= hwdata[4:0];
      if (wr_dp && dp_addr == A_MODE)
        sh_mode <= hwdata[1:0];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  hready_const_a: assert property (hreadyout == 1'b1) else $error("hreadyout dropped");
  resp_okay_a: assert property (hresp == HRESP_OKAY) else $error("hresp not okay");
  active_flag_a: assert property (servo_active == (sh_ctrl[4] && |sh_ctrl[3:0]))
    else $error("servo_active wrong");
  master_zero_a: assert property (!sh_ctrl[4] |=> outs == 32'h0)
    else $error("outputs not zero with master clear");
  upper_zero_a: assert property (rd_dp |-> hrdata[31:8] == 24'h0)
    else $error("read upper bits not zero");
  ctrl_read_a: assert property (
    rd_dp && dp_addr == A_CTRL |-> hrdata == {27'h0, sh_ctrl})
    else $error("control readback wrong");
  mode_read_a: assert property (rd_dp && dp_addr == A_MODE |-> hrdata == {30'h0, sh_mode})
    else $error("mode readback wrong");
  hold_stable_a: assert property (sh_ctrl[4] && !sh_mode[0] |=> $stable(outs))
    else $error("correction moved in hold mode");
  rdata_hold_a: assert property (!(take && !hwrite) |=> $stable(hrdata))
    else $error("hrdata changed without read");
  cover property (sh_mode == 2'b11 && servo_active);
  cover property (rd_dp && dp_addr == A_CTRL);
  cover property (!sh_ctrl[4]);
endmodule : osrv_regs_chk

bind osrv_regs osrv_regs_chk #(.STEP_CYCLES(STEP_CYCLES), .ADDR_W(ADDR_W)) chk_u (
  .core_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
  .hreadyout, .hresp, .hrdata, .offset_high, .headphone_left_out, .headphone_right_out,
  .line_left_out, .line_right_out, .servo_active);

// File: sim/osrv_regs_tb.sv
// osrv_regs_tb: register and servo sequences through the ahb-lite port
// assumes a zero-wait slave whose hreadyout is fed back as hready
`timescale 1ns/1ps
module osrv_regs_tb;
  import osrv_pkg::*;
  localparam int STEP = 4;
  localparam int AW   = 12;
  logic          core_clk    = 1'b0;
  logic          reset       = 1'b1;
  logic          hsel        = 1'b0;
  logic [AW-1:0] haddr       = '0;
  logic [1:0]    htrans      = 2'b00;
  logic          hwrite      = 1'b0;
  logic [2:0]    hsize       = 3'h2;
  logic [31:0]   hwdata      = 32'h0;
  logic [3:0]    offset_high = 4'h0;
  wire           hready;
  wire           hresp;
  wire  [31:0]   hrdata;
  wire  [7:0]    hl, hr, ll, lr;
  wire           servo_active;
  wire  [31:0]   outs = {hl, hr, ll, lr};
  int            err_total = 0;
  int            checks    = 0;
  logic [31:0]   rv;
  logic [7:0]    pre_idx [4] = '{IDX_HP_LEFT_PRESET, IDX_HP_RIGHT_PRESET,
                                 IDX_LINE_LEFT_PRESET, IDX_LINE_RIGHT_PRESET};
  logic [7:0]    rb_idx [4]  = '{IDX_HP_LEFT_INTEG, IDX_HP_RIGHT_INTEG,
                                 IDX_LINE_LEFT_INTEG, IDX_LINE_RIGHT_INTEG};

  osrv_regs #(.STEP_CYCLES(STEP), .ADDR_W(AW)) dut_u (
    .core_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout(hready), .hresp, .hrdata, .offset_high, .headphone_left_out(hl),
    .headphone_right_out(hr), .line_left_out(ll), .line_right_out(lr), .servo_active);

  initial
  begin
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic end_of_test;
    if (err_total == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one edge, then more until hready is seen high, bounded
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge core_clk);
    while (hready !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        err_total++;
        end_of_test;
      end
      @(posedge core_clk);
    end
  endtask : wait_rdy

  task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= AW'({idx, 2'b00});
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    wait_rdy;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy;
    rv = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    bus(idx, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    bus(idx, 1'b0, 32'h0);
    chk(rv, exp);
  endtask : rd

  // junk in the upper bits must not reach the register
  task automatic presets(input logic [31:0] v);
    for (int i = 0; i < 4; i++)
    begin
      wr(pre_idx[i], {24'hffffff, v[31-8*i -: 8]});
      rd(pre_idx[i], {24'h0, v[31-8*i -: 8]});
    end
  endtask : presets

  task automatic state(input logic [31:0] integ, input logic [31:0] out);
    for (int i = 0; i < 4; i++)
      rd(rb_idx[i], {24'h0, integ[31-8*i -: 8]});
    chk(outs, out);
  endtask : state

  initial
  begin
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rd(IDX_SERVO_CONTROL, 32'h10);
    rd(IDX_SERVO_MODE, 32'h0);
    presets(32'h0);
    state(32'h0, 32'h0);
    rd(8'h44, 32'h0);
    presets(32'h7e81827d);
    wr(IDX_SERVO_MODE, {30'h0, MODE_WRITE_APPLY});
    wr(IDX_SERVO_CONTROL, 32'h1f);
    wr(IDX_HP_LEFT_INTEG, 32'h55);
    state(32'h7e81827d, 32'h7e81827d);
    chk({31'h0, servo_active}, 32'h1);
    wr(IDX_SERVO_MODE, {30'h0, MODE_WRITE_HOLD});
    presets(32'h7d837c84);
    state(32'h7d837c84, 32'h7e81827d);
    offset_high <= 4'b0101;
    wr(IDX_SERVO_MODE, {30'h0, MODE_MEASURE_HOLD});
    repeat (12 * STEP) @(posedge core_clk);
    state(32'h7f807f80, 32'h7e81827d);
    wr(IDX_SERVO_MODE, {30'h0, MODE_MEASURE_APPLY});
    state(32'h7f807f80, 32'h7f807f80);
    wr(IDX_SERVO_CONTROL, 32'h18);
    wr(IDX_SERVO_MODE, {30'h0, MODE_WRITE_APPLY});
    presets(32'h10111213);
    state(32'h10807f80, 32'h10807f80);
    wr(IDX_SERVO_CONTROL, 32'h0f);
    rd(IDX_SERVO_CONTROL, 32'h0f);
    state(32'h0, 32'h0);
    chk({31'h0, servo_active}, 32'h0);
    end_of_test;
  end
endmodule : osrv_regs_tb
